// ### acpc_top.sv
// Register and pin-function logic of the eight-pin analog input port
//
// Contract
// - Reset clears the channel select register to zero, choosing analog input 0.
// - Bits 2 to 0 of the channel select register give the binary channel number 0 to 7.
// - A channel select write costs one CPU wait cycle; no such write with peripheral clock off.
// - A pin configuration write costs one CPU wait cycle; no such write with clock off.
// - Reset loads the pin configuration register with 08H, all pins digital.
// - Split value N from 0 to 8 makes the lowest N pins digital and the rest analog.
// - In the delta-sigma variant, edge pins for 1 and 3 and all analog pins for 5 to 7 are SAR only.
// - Reset sets every port direction bit to one, all pins input.
// - Direction bit 0 turns the output buffer on, 1 turns it off.
// - A pin is an analog input only while its direction bit is 1.
// - On the segment variant, a pin assigned to segment output drives segment data whatever the pin configuration.
// - All three registers take single-bit and full-byte writes.
// - A channel select write aborts the conversion, which restarts when the run bit is set.
`timescale 1ns/100ps
module acpc_top #(
   parameter int unsigned NPINS = acpc_pkg::NUM_PINS
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // CPU access
   input wire acpc_pkg::acpc_req_type cpu_req_i,
   output logic [7:0] cpu_rdata_o,
   output logic cpu_wait_o,
   // Device variant and segment controls
   input wire logic variant_ds_i,
   input wire logic [7:0] segment_function_select_i,
   input wire logic [7:0] seg_data_i,
   // Port output latch
   input wire logic [7:0] port_latch_i,
   // Conversion engine
   input wire logic conversion_run_bit_i,
   output logic [2:0] channel_o,
   output logic conv_abort_o,
   output logic conv_restart_o,
   // Pin functions
   output logic [7:0] pin_oe_o,
   output logic [7:0] pin_out_o,
   output logic [7:0] digital_in_en_o,
   output logic [7:0] ana_avail_o,
   output logic [7:0] sar_ok_o,
   output logic [7:0] ds_ok_o
);
   if (NPINS != acpc_pkg::NUM_PINS) begin : g_bad_pins
      $error("acpc_top serves exactly eight pins");
   end

   logic [7:0] chan_sel_q;
   logic [7:0] pin_cfg_q;
   logic [7:0] port_dir_q;

   // Byte write or single-bit replace
   function automatic logic [7:0] merge_wr(input logic [7:0] old,
                                           input acpc_pkg::acpc_req_type r);
      logic [7:0] v;
      v = old;
      if (r.bit_op) begin
         v[r.bit_sel] = r.wdata[0];
      end else begin
         v = r.wdata;
      end
      return v;
   endfunction : merge_wr

   wire chan_wr = cpu_req_i.wr && cpu_req_i.addr == acpc_pkg::ADDR_CHAN_SEL;
   wire cfg_wr = cpu_req_i.wr && cpu_req_i.addr == acpc_pkg::ADDR_PIN_CFG;
   wire dir_wr = cpu_req_i.wr && cpu_req_i.addr == acpc_pkg::ADDR_PORT_DIR;
   // Upper bits held at zero so reads return zero
   wire [7:0] chan_sel_d = merge_wr(chan_sel_q, cpu_req_i) & acpc_pkg::MASK_CHAN_SEL;
   wire [7:0] pin_cfg_d = merge_wr(pin_cfg_q, cpu_req_i) & acpc_pkg::MASK_PIN_CFG;
   wire [7:0] port_dir_d = merge_wr(port_dir_q, cpu_req_i);
   wire [7:0] rdata_d = (cpu_req_i.addr == acpc_pkg::ADDR_CHAN_SEL) ? chan_sel_q :
                        (cpu_req_i.addr == acpc_pkg::ADDR_PIN_CFG) ? pin_cfg_q :
                        (cpu_req_i.addr == acpc_pkg::ADDR_PORT_DIR) ? port_dir_q : 8'h00;
   wire [3:0] split = pin_cfg_q[acpc_pkg::SPLIT_MSB:0];
   wire sar_band = split >= acpc_pkg::SPLIT_SAR_LO && split <= acpc_pkg::SPLIT_SAR_HI;
   // Segment function exists only on the segment variant
   wire [7:0] seg_sel = segment_function_select_i & {8{!variant_ds_i}};
   // Prohibited split values above 8 fall out as all digital
   logic [7:0] analog_cfg;
   logic [7:0] sar_only;
   logic [7:0] ana_avail_d;

   for (genvar i = 0; i < 8; i++) begin : g_pin
      wire edge_pin = (split == acpc_pkg::SPLIT_SAR_EDGE_A && i == 1) ||
                      (split == acpc_pkg::SPLIT_SAR_EDGE_B && i == 3);
      assign analog_cfg[i] = split <= 4'(i);
      assign sar_only[i] = variant_ds_i && (edge_pin || sar_band);
      // Analog needs input mode and no segment override
      assign ana_avail_d[i] = analog_cfg[i] && port_dir_q[i] && !seg_sel[i];
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         chan_sel_q <= acpc_pkg::RST_CHAN_SEL;
         pin_cfg_q <= acpc_pkg::RST_PIN_CFG;
         port_dir_q <= acpc_pkg::RST_PORT_DIR;
      end else begin
         if (chan_wr) begin
            chan_sel_q <= chan_sel_d;
         end
         if (cfg_wr) begin
            pin_cfg_q <= pin_cfg_d;
         end
         if (dir_wr) begin
            port_dir_q <= port_dir_d;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         cpu_rdata_o <= 8'h00;
         cpu_wait_o <= 1'b0;
         conv_abort_o <= 1'b0;
         conv_restart_o <= 1'b0;
      end else begin
         cpu_rdata_o <= cpu_req_i.rd ? rdata_d : 8'h00;
         cpu_wait_o <= chan_wr || cfg_wr;
         conv_abort_o <= chan_wr;
         conv_restart_o <= chan_wr && conversion_run_bit_i;
      end
   end

   // Pin outputs trail the registers by one cycle so every port is a flop
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         channel_o <= 3'h0;
         pin_oe_o <= 8'h00;
         pin_out_o <= 8'h00;
         digital_in_en_o <= 8'h00;
         ana_avail_o <= 8'h00;
         sar_ok_o <= 8'h00;
         ds_ok_o <= 8'h00;
      end else begin
         channel_o <= chan_sel_q[acpc_pkg::CHAN_MSB:0];
         pin_oe_o <= ~port_dir_q | seg_sel;
         pin_out_o <= (seg_sel & seg_data_i) |
                      (~seg_sel & ~port_dir_q & port_latch_i);
         digital_in_en_o <= ~analog_cfg & port_dir_q & ~seg_sel;
         ana_avail_o <= ana_avail_d;
         sar_ok_o <= ana_avail_d;
         ds_ok_o <= ana_avail_d & ~sar_only & {8{variant_ds_i}};
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_chan_reset_zero: assert property ($rose(rst_n_i) |-> chan_sel_q == 8'h00)
      else $error("channel select not zero after reset");
   a_cfg_reset_value: assert property ($rose(rst_n_i) |-> pin_cfg_q == 8'h08)
      else $error("pin configuration not 08H after reset");
   a_dir_reset_ones: assert property ($rose(rst_n_i) |-> port_dir_q == 8'hff)
      else $error("port direction not FFH after reset");
   a_upper_bits_zero: assert property (chan_sel_q[7:3] == 5'h00 && pin_cfg_q[7:4] == 4'h0)
      else $error("unused upper bits not zero");
   a_chan_wait_cycle: assert property (chan_wr |=> cpu_wait_o)
      else $error("no wait after channel select write");
   a_cfg_wait_cycle: assert property (cfg_wr |=> cpu_wait_o)
      else $error("no wait after pin configuration write");
   a_wait_has_cause: assert property (cpu_wait_o |-> $past(chan_wr || cfg_wr))
      else $error("wait without a write");
   a_channel_byte_wr: assert property (chan_wr && !cpu_req_i.bit_op |=>
      ##1 channel_o == $past(cpu_req_i.wdata[2:0], 2))
      else $error("channel output does not follow byte write");
   a_dir_bit_write: assert property (dir_wr && cpu_req_i.bit_op |=>
      port_dir_q[$past(cpu_req_i.bit_sel)] == $past(cpu_req_i.wdata[0]))
      else $error("single-bit direction write lost");
   a_all_digital: assert property ($past(pin_cfg_q) == 8'h08 |-> ana_avail_o == 8'h00)
      else $error("analog pin while split is 8");
   a_analog_input_only: assert property ((ana_avail_o & ~$past(port_dir_q)) == 8'h00)
      else $error("analog pin in output mode");
   // Pin outputs still hold reset values at the first edge after reset, so skip that edge
   a_buffer_dir: assert property ($past(rst_n_i) |-> pin_oe_o ==
      ($past(~port_dir_q) | $past(seg_sel)))
      else $error("output buffer does not follow direction");
   a_segment_wins: assert property ($past(rst_n_i) |->
      (pin_out_o & $past(seg_sel)) == ($past(seg_data_i) & $past(seg_sel)))
      else $error("segment data not driven");
   a_latch_drives: assert property ($past(rst_n_i) |->
      (pin_out_o & ~$past(seg_sel)) ==
      (~$past(port_dir_q) & $past(port_latch_i) & ~$past(seg_sel)))
      else $error("output latch not driven in output mode");
   a_ds_band_sar: assert property ($past(variant_ds_i) && $past(split) >= 4'h5 &&
      $past(split) <= 4'h7 |-> ds_ok_o == 8'h00)
      else $error("delta-sigma allowed for split 5 to 7");
   a_sar_equals_avail: assert property (sar_ok_o == ana_avail_o)
      else $error("SAR permission differs from analog availability");
   a_ds_needs_analog: assert property ((ds_ok_o & ~ana_avail_o) == 8'h00)
      else $error("delta-sigma allowed on a non-analog pin");
   a_input_path_split: assert property ((digital_in_en_o & ana_avail_o) == 8'h00)
      else $error("pin both digital input and analog");
   a_restart_on_run: assert property (chan_wr && conversion_run_bit_i |=>
      conv_abort_o && conv_restart_o)
      else $error("conversion not restarted after channel write");
   a_abort_every_write: assert property (chan_wr |=> conv_abort_o)
      else $error("no abort after channel select write");
   a_abort_has_cause: assert property (conv_abort_o |-> $past(chan_wr))
      else $error("abort without a channel select write");
   a_restart_has_cause: assert property (conv_restart_o |->
      $past(chan_wr && conversion_run_bit_i))
      else $error("restart without a write while running");
   a_channel_follows: assert property ($past(rst_n_i) |->
      channel_o == $past(chan_sel_q[acpc_pkg::CHAN_MSB:0]))
      else $error("channel output does not follow register");
   a_cfg_byte_write: assert property (cfg_wr && !cpu_req_i.bit_op |=>
      pin_cfg_q == ($past(cpu_req_i.wdata) & acpc_pkg::MASK_PIN_CFG))
      else $error("pin configuration byte write lost");
   a_dir_byte_write: assert property (dir_wr && !cpu_req_i.bit_op |=>
      port_dir_q == $past(cpu_req_i.wdata))
      else $error("direction byte write lost");
   a_read_upper_zero: assert property ($past(cpu_req_i.rd) &&
      $past(cpu_req_i.addr) == acpc_pkg::ADDR_CHAN_SEL |-> cpu_rdata_o[7:3] == 5'h00)
      else $error("channel select read shows upper bits");

   c_write_while_run: cover property (chan_wr && conversion_run_bit_i);
   c_dir_bit_write: cover property (dir_wr && cpu_req_i.bit_op);
   c_ds_edge_pin: cover property (variant_ds_i && split == 4'h3 ##2 sar_ok_o[3] && !ds_ok_o[3]);
   c_segment_override: cover property (!variant_ds_i && segment_function_select_i != 8'h00);
   c_all_analog: cover property (pin_cfg_q == 8'h00 && port_dir_q == 8'hff ##2
      ana_avail_o == 8'hff);
endmodule : acpc_top

// ### acpc_pkg.sv
// Constants and carrier types for the analog channel and pin configuration block
package acpc_pkg;
   localparam int unsigned NUM_PINS = 8;
   localparam logic [15:0] ADDR_PORT_DIR = 16'hff22;
   localparam logic [15:0] ADDR_CHAN_SEL = 16'hff8e;
   localparam logic [15:0] ADDR_PIN_CFG = 16'hff8f;
   localparam logic [7:0] RST_PORT_DIR = 8'hff;
   localparam logic [7:0] RST_CHAN_SEL = 8'h00;
   localparam logic [7:0] RST_PIN_CFG = 8'h08;
   localparam logic [7:0] MASK_CHAN_SEL = 8'h07;
   localparam logic [7:0] MASK_PIN_CFG = 8'h0f;
   localparam logic [3:0] SPLIT_ALL_DIGITAL = 4'h8;
   localparam logic [3:0] SPLIT_SAR_EDGE_A = 4'h1;
   localparam logic [3:0] SPLIT_SAR_EDGE_B = 4'h3;
   localparam logic [3:0] SPLIT_SAR_LO = 4'h5;
   localparam logic [3:0] SPLIT_SAR_HI = 4'h7;
   localparam int unsigned CHAN_MSB = 2;
   localparam int unsigned SPLIT_MSB = 3;

   // CPU access: full byte or single bit, bit value carried in wdata[0]
   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic bit_op;
      logic [2:0] bit_sel;
      logic [7:0] wdata;
   } acpc_req_type;
endpackage : acpc_pkg

// ### adc_channel_pin_config_tb.sv
// Self-checking bench for the analog channel and pin configuration block
`timescale 1ns/100ps
module adc_channel_pin_config_tb;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   acpc_pkg::acpc_req_type req = '0;
   logic ds = 1'b0;
   logic run = 1'b0;
   logic [7:0] segsel = 8'h00, segd = 8'h00, latch = 8'h00, lf = 8'h14, d = 8'hff;
   logic [7:0] rdata, oe, pout, din, ana, sar, dsok;
   logic wt, abt, rs;
   logic [2:0] chan;
   logic [15:0] adr [4] = '{16'hff22, 16'hff8e, 16'hff8f, 16'h1234};
   logic [7:0] rv [4] = '{8'hff, 8'h00, 8'h08, 8'h00};
   int miscompares = 0;
   int n_tests = 0;
   acpc_top u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cpu_req_i(req),
      .cpu_rdata_o(rdata), .cpu_wait_o(wt), .variant_ds_i(ds),
      .segment_function_select_i(segsel), .seg_data_i(segd), .port_latch_i(latch),
      .conversion_run_bit_i(run), .channel_o(chan), .conv_abort_o(abt),
      .conv_restart_o(rs), .pin_oe_o(oe), .pin_out_o(pout), .digital_in_en_o(din),
      .ana_avail_o(ana), .sar_ok_o(sar), .ds_ok_o(dsok));
   initial begin
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   function automatic logic [7:0] nxt(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : nxt
   // Split decode: values above 8 treated as all digital
   function automatic logic [7:0] ana_exp(input logic [3:0] n);
      return (n > 4'h8) ? 8'h00 : 8'hff << n;
   endfunction : ana_exp
   function automatic logic [7:0] ds_exp(input logic [3:0] n);
      logic [7:0] e;
      e = ana_exp(n);
      if (n == 4'h1 || n == 4'h3) e[n] = 1'b0;
      if (n >= 4'h5) e = 8'h00;
      return e;
   endfunction : ds_exp
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One access, request held for exactly one sampling edge
   task automatic acc(input logic [15:0] a, input logic w, input logic b,
                      input logic [2:0] s, input logic [7:0] v);
      @(posedge sys_clk_i);
      req <= '{addr: a, wr: w, rd: !w, bit_op: b, bit_sel: s, wdata: v};
      @(posedge sys_clk_i);
      req <= '0;
      #1;
   endtask : acc
   // Pin outputs lag a register write by one more edge
   task automatic settle();
      @(posedge sys_clk_i);
      #1;
   endtask : settle
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   initial begin
      #400000;
      miscompares++;
      give_verdict();
   end
   initial begin
      repeat (12) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         acc(adr[i], 1'b0, 1'b0, 3'h0, 8'h00);
         chk(rdata, rv[i]);
      end
      $display("reset values done");
      acc(16'hff8f, 1'b1, 1'b0, 3'h0, 8'h00);
      for (int i = 0; i < 16; i++) begin
         lf = nxt(lf);
         run <= lf[7];
         acc(16'hff8e, 1'b1, 1'b0, 3'h0, {5'h00, lf[2:0]});
         chk({5'h00, wt, abt, rs}, {5'h00, 2'b11, run});
         acc(16'hff8e, 1'b1, 1'b1, 3'h2, {7'h00, ~lf[2]});
         settle();
         chk({5'h00, chan}, {5'h00, ~lf[2], lf[1:0]});
         acc(16'hff8e, 1'b0, 1'b0, 3'h0, 8'h00);
         chk(rdata, {5'h00, ~lf[2], lf[1:0]});
      end
      $display("channel select done");
      for (int v = 0; v < 2; v++) begin
         for (int n = 0; n < 9; n++) begin
            ds <= v[0]; // Second pass selects the delta-sigma variant
            acc(16'hff8f, 1'b1, 1'b0, 3'h0, 8'(n));
            chk({7'h00, wt}, 8'h01);
            settle();
            chk(ana, ana_exp(4'(n)));
            chk(din, ~ana_exp(4'(n)));
            chk(sar, ana_exp(4'(n)));
            chk(dsok, v ? ds_exp(4'(n)) : 8'h00);
         end
      end
      $display("pin split done");
      ds <= 1'b0;
      acc(16'hff8f, 1'b1, 1'b1, 3'h3, 8'h00);
      for (int k = 0; k < 8; k++) begin
         lf = nxt(lf);
         latch <= lf;
         d[k] = 1'b0;
         acc(16'hff22, 1'b1, 1'b1, 3'(k), 8'h00);
         settle();
         chk(oe, ~d);
         chk(pout, ~d & latch);
         chk(ana, d);
      end
      acc(16'hff22, 1'b0, 1'b0, 3'h0, 8'h00);
      chk(rdata, 8'h00);
      acc(16'hff22, 1'b1, 1'b0, 3'h0, 8'hff);
      d = 8'hff;
      $display("direction done");
      for (int i = 0; i < 6; i++) begin
         lf = nxt(lf);
         segsel <= lf;
         segd <= nxt(lf);
         settle();
         settle();
         chk(oe, segsel);
         chk(pout, segsel & segd);
         chk(ana, ~segsel);
      end
      $display("segment done");
      @(posedge sys_clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         acc(adr[i], 1'b0, 1'b0, 3'h0, 8'h00);
         chk(rdata, rv[i]);
      end
      settle();
      chk(oe, segsel);
      chk(ana, 8'h00);
      $display("mid-run reset done");
      give_verdict();
   end
endmodule : adc_channel_pin_config_tb
